// ### rtl/wgt_pkg.sv
// package for the window guard timer: register map, fields, reset values, timing
// assumes a 32-bit register port clocked by the peripheral bus clock
package wgt_pkg;
    localparam logic [3:0]  WGT_OFS_CTRL      = 4'h0;
    localparam logic [3:0]  WGT_OFS_CFG       = 4'h4;
    localparam logic [3:0]  WGT_OFS_STS       = 4'h8;
    localparam int          WGT_CNT_W         = 7;
    localparam logic [6:0]  WGT_CNT_RST       = 7'h7f;
    localparam logic [6:0]  WGT_WIN_RST       = 7'h7f;
    localparam logic [6:0]  WGT_WARN_VAL      = 7'h40;
    localparam logic [6:0]  WGT_FIRE_VAL      = 7'h3f;
    localparam int          WGT_CNT_HI        = 6;
    localparam int          WGT_EN_BIT        = 7;
    localparam int          WGT_DIV_LO        = 7;
    localparam int          WGT_DIV_HI        = 8;
    localparam int          WGT_IRQEN_BIT     = 9;
    localparam int          WGT_FLAG_BIT      = 0;
    localparam int          WGT_PRE_DIV       = 4096;
    localparam int          WGT_PRE_W         = 12;
    localparam logic [11:0] WGT_PRE_LAST      = 12'(WGT_PRE_DIV - 1);
    localparam int          WGT_EXP_W         = 3;
    localparam logic [31:0] WGT_ZERO          = 32'h0000_0000;
endpackage

// ### rtl/wgt_tick_divider.sv
// prescaler: peripheral clock /4096, then /1,/2,/4,/8
// assumes synchronous active-high reset
`timescale 1ns/1ps
module wgt_tick_divider
    import wgt_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    wgt_tick_if.pre   tk
);
    logic [WGT_PRE_W-1:0] pre_ff;
    logic [WGT_EXP_W-1:0] sub_ff;
    logic                 tick_ff;
    wire                  pre_wrap = (pre_ff == WGT_PRE_LAST);
    // sub stage counts 2^exp prescaler wraps; free running keeps phase simple
    wire [WGT_EXP_W-1:0]  sub_mask = WGT_EXP_W'((1 << tk.timebase_exponent) - 1);
    wire                  sub_done = ((sub_ff & sub_mask) == sub_mask);
    wire [WGT_PRE_W-1:0]  nxt_pre = pre_wrap ? '0 : pre_ff + 1'b1;
    wire [WGT_EXP_W-1:0]  nxt_sub = pre_wrap ? sub_ff + 1'b1 : sub_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_ff  <= '0;
            sub_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            sub_ff  <= nxt_sub;
            tick_ff <= pre_wrap && sub_done;
        end
    end
    assign tk.tick = tick_ff;
endmodule

// ### rtl/wgt_tick_if.sv
// interface carrying the divided tick from the prescaler to the counter logic
// assumes one clock domain
`timescale 1ns/1ps
interface wgt_tick_if;
    logic [1:0] timebase_exponent;
    logic       tick;
    modport pre (input timebase_exponent, output tick);
    modport cnt (output timebase_exponent, input tick);
endinterface

// ### rtl/wgt_window_guard_timer.sv
// window guard timer top: registers, down counter, early warning, reset request
// assumes single-cycle register port strobes; sys_reset_req is taken by the reset unit
//
// Functional notes
// - seven-bit down counter in control bits 6:0, read/write, resets to 0x7f
// - when enabled, reset is raised as count steps from 0x40 to 0x3f
// - enable bit 7 is set by writing one; only reset clears it
// - config bits 6:0 hold window limit, read/write, reset 0x7f
// - tick is bus clock /4096 then /1,/2,/4,/8 from config bits 8:7
// - irq enable bit 9 raises interrupt at 0x40; set-only, reset clears
// - early warning flag set whenever a tick takes count to 0x40, irq enabled or not
// - writing zero clears the flag, writing one keeps it; reset value zero
// - half-word and word accesses both accepted on all three registers
// - timeout equals clock period times 4096 times 2^exp times low bits plus one
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module wgt_window_guard_timer
    import wgt_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  wsize,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             early_warn_irq,
    output logic             sys_reset_req
);
    wgt_tick_if tk();

    logic [6:0]  down_count_ff;
    logic        guard_enable_ff;
    logic [6:0]  window_limit_ff;
    logic [1:0]  tick_divider_ff;
    logic        early_warn_irq_enable_ff;
    logic        early_warn_flag_ff;
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic        rst_req_ff;

    wgt_tick_divider u_div (
        .clock (clock),
        .rst   (rst),
        .tk    (tk)
    );
    assign tk.timebase_exponent = tick_divider_ff;

    // all fields live in the low half-word, so a half-word access behaves as a word
    wire wr_ctrl = wr && (addr == WGT_OFS_CTRL);
    wire wr_cfg  = wr && (addr == WGT_OFS_CFG);
    wire wr_sts  = wr && (addr == WGT_OFS_STS);

    wire [6:0] wr_count   = wdata[WGT_CNT_HI:0];
    wire       tick_dec   = tk.tick;
    wire [6:0] dec_count  = down_count_ff - 7'h01;
    // a tick that lands with a control write is dropped: the written value wins
    wire [6:0] nxt_down_count = wr_ctrl ? wr_count
                              : (tick_dec ? dec_count : down_count_ff);
    wire       nxt_guard_enable = guard_enable_ff
                              | (wr_ctrl & wdata[WGT_EN_BIT]);
    wire [6:0] nxt_window_limit = wr_cfg ? wdata[WGT_CNT_HI:0] : window_limit_ff;
    wire [1:0] nxt_tick_divider = wr_cfg ? wdata[WGT_DIV_HI:WGT_DIV_LO]
                              : tick_divider_ff;
    wire       nxt_irq_enable = early_warn_irq_enable_ff
                              | (wr_cfg & wdata[WGT_IRQEN_BIT]);

    // count reaching 0x40 on a tick
    wire warn_hit  = tick_dec && !wr_ctrl && (dec_count == WGT_WARN_VAL);
    // step 0x40 -> 0x3f
    wire fire_step = tick_dec && !wr_ctrl && (down_count_ff == WGT_WARN_VAL)
                   && (dec_count == WGT_FIRE_VAL);
    // reload while still above the window is a fault
    wire early_reload = wr_ctrl && (down_count_ff > window_limit_ff);
    // enable written in the same cycle counts, so a late enable still guards
    wire guard_on  = guard_enable_ff || (wr_ctrl & wdata[WGT_EN_BIT]);
    wire nxt_rst_req = guard_on && (fire_step || early_reload);

    // set beats clear when an event meets a clearing write
    wire flag_clr = wr_sts && !wdata[WGT_FLAG_BIT];
    wire nxt_flag = warn_hit | (early_warn_flag_ff & ~flag_clr);
    wire nxt_irq  = nxt_flag & nxt_irq_enable;

    wire [31:0] rd_ctrl = {24'h00_0000, guard_enable_ff, down_count_ff};
    wire [31:0] rd_cfg  = {22'h00_0000, early_warn_irq_enable_ff, tick_divider_ff,
                           window_limit_ff};
    wire [31:0] rd_sts  = {31'h0000_0000, early_warn_flag_ff};
    wire [31:0] rd_mux  = (addr == WGT_OFS_CTRL) ? rd_ctrl
                        : (addr == WGT_OFS_CFG)  ? rd_cfg
                        : (addr == WGT_OFS_STS)  ? rd_sts
                        : WGT_ZERO;
    // read data valid only in the cycle after the strobe; unmapped reads zero
    wire [31:0] nxt_rdata = rd ? rd_mux : WGT_ZERO;

    always_ff @(posedge clock) begin
        if (rst) begin
            down_count_ff            <= WGT_CNT_RST;
            guard_enable_ff          <= 1'b0;
            window_limit_ff          <= WGT_WIN_RST;
            tick_divider_ff          <= 2'h0;
            early_warn_irq_enable_ff <= 1'b0;
            early_warn_flag_ff       <= 1'b0;
        end else begin
            down_count_ff            <= nxt_down_count;
            guard_enable_ff          <= nxt_guard_enable;
            window_limit_ff          <= nxt_window_limit;
            tick_divider_ff          <= nxt_tick_divider;
            early_warn_irq_enable_ff <= nxt_irq_enable;
            early_warn_flag_ff       <= nxt_flag;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff   <= WGT_ZERO;
            irq_ff     <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            rdata_ff   <= nxt_rdata;
            irq_ff     <= nxt_irq;
            // held until the system reset loops back through rst
            rst_req_ff <= rst_req_ff | nxt_rst_req;
        end
    end

    assign rdata          = rdata_ff;
    assign early_warn_irq = irq_ff;
    assign sys_reset_req  = rst_req_ff;
endmodule

// ### tb/wgt_window_guard_timer_properties.sv
// checker for the window guard timer register port and outputs
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module wgt_window_guard_timer_properties
    import wgt_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0]  wsize,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        early_warn_irq,
    input wire logic        sys_reset_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == WGT_ZERO)
        else $error("rdata not zero outside read slot");
    a_ctrl_reserved_zero: assert property ($past(rd) && $past(addr) == WGT_OFS_CTRL
        |-> rdata[31:8] == 24'h00_0000)
        else $error("ctrl reserved bits set");
    a_sts_reserved_zero: assert property ($past(rd) && $past(addr) == WGT_OFS_STS
        |-> rdata[31:1] == 31'h0)
        else $error("sts reserved bits set");
    a_cfg_read_back: assert property (wr && addr == WGT_OFS_CFG
        ##1 rd && addr == WGT_OFS_CFG |=> rdata[8:0] == $past(wdata[8:0], 2))
        else $error("cfg read back wrong");
    a_unmapped_read_zero: assert property ($past(rd) && $past(addr) > WGT_OFS_STS
        |-> rdata == WGT_ZERO)
        else $error("unmapped read not zero");
    a_reset_req_sticky: assert property (sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped");
    a_irq_holds: assert property (early_warn_irq && !(wr && addr == WGT_OFS_STS)
        |=> early_warn_irq)
        else $error("irq dropped without clear");
    a_release_quiet: assert property ($fell(rst)
        |-> !sys_reset_req && !early_warn_irq)
        else $error("outputs active after reset");
    a_sts_clear_reads: assert property (wr && addr == WGT_OFS_STS && !wdata[0]
        ##1 rd && addr == WGT_OFS_STS |=> rdata[0] == 1'b0)
        else $error("flag not cleared");
endmodule
bind wgt_window_guard_timer wgt_window_guard_timer_properties chk (.*);

// ### tb/wgt_window_guard_timer_test.sv
// self-checking bench for the window guard timer
// assumes 10 MHz clock; tick period fixed at 4096 clocks with divider code 00
`timescale 1ns/1ps
module wgt_window_guard_timer_test;
    import wgt_pkg::*;
    logic clock = 0, rst = 1, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0] wsize = 2'b10;
    logic early_warn_irq, sys_reset_req;
    int n_errors = 0, check_count = 0, i;
    wgt_window_guard_timer uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wsize(wsize), .wr(wr), .rd(rd), .rdata(rdata), .early_warn_irq(early_warn_irq),
        .sys_reset_req(sys_reset_req));
    initial begin
        forever #50 clock = ~clock;
    end
    task test_done;
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task acc(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
        wr <= w; rd <= r; addr <= a; wdata <= d;
        @(posedge clock);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        acc(0, 1, a, 0);
        #1 chk("rdata", e, rdata);
    endtask
    // bounded: 9000 clocks, just over two ticks at divider code 00
    task wait_hi(input int s);
        i = 0;
        while ((s ? sys_reset_req : early_warn_irq) !== 1'b1 && i < 9000) begin
            @(posedge clock); i++;
        end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 0;
        rdc(WGT_OFS_CTRL, 32'h0000_007f);
        rdc(WGT_OFS_CFG, 32'h0000_007f);
        rdc(WGT_OFS_STS, 32'h0000_0000);
        rdc(4'hc, 32'h0000_0000);
        acc(1, 0, WGT_OFS_CFG, 32'h0000_027f);
        rdc(WGT_OFS_CFG, 32'h0000_027f);
        acc(1, 0, WGT_OFS_CFG, 32'h0000_007f);
        rdc(WGT_OFS_CFG, 32'h0000_027f);
        acc(1, 0, WGT_OFS_CTRL, 32'h0000_0041);
        acc(0, 0, 0, 0);
        wait_hi(0);
        chk("irq", 1, early_warn_irq);
        rdc(WGT_OFS_STS, 32'h0000_0001);
        rdc(WGT_OFS_CTRL, 32'h0000_0040);
        wsize <= 2'b01;
        acc(1, 0, WGT_OFS_STS, 32'h0000_0001);
        rdc(WGT_OFS_STS, 32'h0000_0001);
        acc(1, 0, WGT_OFS_STS, 32'h0000_0000);
        rdc(WGT_OFS_STS, 32'h0000_0000);
        chk("irq", 0, early_warn_irq);
        // one tick of 4096 clocks must pass; disabled so no reset
        acc(0, 0, 0, 0);
        repeat (4200) @(posedge clock);
        rdc(WGT_OFS_CTRL, 32'h0000_003f);
        chk("sysrst", 0, sys_reset_req);
        acc(1, 0, WGT_OFS_CTRL, 32'h0000_00c1);
        acc(1, 0, WGT_OFS_CTRL, 32'h0000_0041);
        rdc(WGT_OFS_CTRL, 32'h0000_00c1);
        chk("sysrst", 0, sys_reset_req);
        acc(0, 0, 0, 0);
        wait_hi(1);
        chk("sysrst", 1, sys_reset_req);
        rdc(WGT_OFS_CTRL, 32'h0000_00bf);
        acc(0, 0, 0, 0);
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        rdc(WGT_OFS_CTRL, 32'h0000_007f);
        chk("sysrst", 0, sys_reset_req);
        // divide by two: the first prescaler wrap gives no tick, the second does
        acc(1, 0, WGT_OFS_CFG, 32'h0000_00ff);
        acc(0, 0, 0, 0);
        repeat (4200) @(posedge clock);
        rdc(WGT_OFS_CTRL, 32'h0000_007f);
        acc(0, 0, 0, 0);
        repeat (4100) @(posedge clock);
        rdc(WGT_OFS_CTRL, 32'h0000_007e);
        acc(1, 0, WGT_OFS_CFG, 32'h0000_0050);
        acc(1, 0, WGT_OFS_CTRL, 32'h0000_00ff);
        acc(0, 0, 0, 0);
        #1 chk("sysrst", 1, sys_reset_req);
        test_done;
    end
    initial begin
        #6ms;
        n_errors++;
        test_done;
    end
endmodule
